// ===== logic/eidi_top.sv
`timescale 1ns/100ps
// How it works
// - shared group byte address is decoded independently of the module address
// - only the master acknowledges the shared byte; every module with the acknowledge jumper fitted or in interrupt mode drives its bit
// - a bit-select switch places a slave module on one of eight shared bits; the master always uses bit 0
// - bytes read ascending; first read freezes inputs, fourth read releases
// - interrupt mode: a qualifying change raises the selected backplane line
// - pending memory keeps setting while stopped; startup full read clears it
// - pending memory clears only on a full four-byte read
// - with acknowledge jumper fitted the shared byte is acknowledged by the master only
// - with acknowledge jumper removed the shared byte is never acknowledged
// - in interrupt mode the shared byte bit identifies the source module
// - bytes with edge selection off never trigger anything
// - a route switch puts the request onto line a to g or general line
// - per-byte edge selection picks the triggering transition
// - each byte applies its own 0.3, 1.0 or 3.0 ms input delay
// - master jumper fitted means master, removed means slave
// - group signal generation only with group jumper fitted or in interrupt mode
// - edge setting: rising, falling, both or none
// - ready acknowledge only for the four bytes from the module address switch, or for the shared byte at the master
module eidi_top #(
  parameter int unsigned SHORT_CYC = eidi_pkg::DLY_SHORT_CYC,
  parameter int unsigned MID_CYC = eidi_pkg::DLY_MID_CYC,
  parameter int unsigned LONG_CYC = eidi_pkg::DLY_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [31:0] pin_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_data_o,
  output logic bus_data_oe_o,
  output logic bus_rdy_o,
  input wire logic [7:0] base_address_switch_i,
  input wire logic [2:0] group_bit_select_switch_i,
  input wire logic [7:0] irq_line_route_switch_i,
  input wire logic [7:0] edge_select_switch_i,
  input wire logic [7:0] input_delay_switch_i,
  input wire logic master_select_jumper_i,
  input wire logic group_ack_jumper_i,
  input wire logic irq_mode_i,
  output logic [7:0] irq_line_o,
  output logic pending_o,
  output logic frozen_o
);
  logic [7:0] val [4];
  logic [3:0] pend;
  logic [1:0] scan_q;
  logic frozen_q;
  logic [7:0] data_q;
  logic oe_q, rdy_q, rd_q;
  logic clear_q;
  // reads are taken on the rising strobe edge only, so a held strobe counts once
  wire rd_start = bus_rd_i && !rd_q;
  wire [7:0] offs = bus_addr_i - base_address_switch_i;
  wire own_hit = (bus_addr_i - base_address_switch_i) < 8'h04 &&
                 (base_address_switch_i <= 8'hfc);
  wire [1:0] byte_idx = offs[1:0];
  wire shared_hit = (bus_addr_i == eidi_pkg::SHARED_ADDR);
  wire any_pend = |pend;
  // the shared bit is driven in group mode with the group jumper, or in interrupt mode
  wire shared_active = group_ack_jumper_i || irq_mode_i;
  wire [2:0] my_bit = master_select_jumper_i ? 3'h0 : group_bit_select_switch_i;
  wire shared_ack = shared_hit && group_ack_jumper_i && master_select_jumper_i;
  wire [7:0] shared_val = (shared_active && any_pend) ? (8'h01 << my_bit) : 8'h00;
  wire drive_shared = shared_hit && shared_active;
  // in-order scan: byte k is accepted only when k is the next expected
  wire in_order = own_hit && (byte_idx == scan_q);
  wire last_read = rd_start && in_order && (byte_idx == 2'h3);
  wire first_read = rd_start && in_order && (byte_idx == 2'h0);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      eidi_byte_filter #(
        .SHORT_CYC(SHORT_CYC),
        .MID_CYC(MID_CYC),
        .LONG_CYC(LONG_CYC)
      ) u_byte (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pin_i[8*g+:8]),
        .dly_sel_i(input_delay_switch_i[2*g+:2]),
        .edge_sel_i(edge_select_switch_i[2*g+:2]),
        .freeze_i(frozen_q),
        .clear_i(clear_q),
        .value_o(val[g]),
        .pend_o(pend[g])
      );
    end
  endgenerate
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q <= 1'b0;
      scan_q <= eidi_pkg::SCAN_RST;
      frozen_q <= 1'b0;
      data_q <= 8'h00;
      oe_q <= 1'b0;
      rdy_q <= 1'b0;
      clear_q <= 1'b0;
    end else begin
      rd_q <= bus_rd_i;
      clear_q <= last_read;
      if (rd_start && in_order) scan_q <= scan_q + 2'h1;
      if (first_read) frozen_q <= 1'b1;
      else if (last_read) frozen_q <= 1'b0;
      rdy_q <= rd_start && (own_hit || shared_ack);
      oe_q <= rd_start && (own_hit || drive_shared);
      if (rd_start && own_hit) data_q <= val[byte_idx];
      else if (rd_start && drive_shared) data_q <= shared_val;
      else if (!bus_rd_i) data_q <= 8'h00;
    end
  end
  // interrupt request is a level held until the full scan clears it
  wire irq_level = irq_mode_i && any_pend;
  assign irq_line_o = irq_level ? irq_line_route_switch_i : 8'h00;
  assign bus_data_o = data_q;
  assign bus_data_oe_o = oe_q;
  assign bus_rdy_o = rdy_q;
  assign pending_o = any_pend;
  assign frozen_o = frozen_q;

  chk_clear_after_scan: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    last_read |=> clear_q) else $error("scan clear missing");
  chk_pend_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(any_pend) |-> $past(clear_q)) else $error("pending dropped without scan");
  chk_freeze_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    first_read |=> frozen_q) else $error("first read did not freeze");
  chk_freeze_rel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    last_read |=> !frozen_q) else $error("fourth read did not release");
  chk_slave_no_ack: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_start && shared_hit && !master_select_jumper_i) |=> !rdy_q) else $error("slave acked shared");
  chk_ack_jumper: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_start && shared_hit && !group_ack_jumper_i) |=> !rdy_q) else $error("shared acked jumper off");
  chk_own_ack: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rdy_q |-> $past(own_hit) || $past(shared_ack)) else $error("ack without match");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (irq_mode_i && any_pend) |-> irq_line_o == irq_line_route_switch_i) else $error("irq not driven");
  chk_no_irq_grp: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !irq_mode_i |-> irq_line_o == 8'h00) else $error("irq in group mode");
  cov_full_scan: cover property (@(posedge clk_i) disable iff (!arst_n_i) first_read ##[1:50] last_read);
  cov_irq: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(irq_level));
  cov_shared: cover property (@(posedge clk_i) disable iff (!arst_n_i) rd_start && drive_shared);
endmodule : eidi_top

// ===== logic/eidi_pkg.sv
package eidi_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // input delay figures in microseconds
  localparam int unsigned DLY_SHORT_US = 300;
  localparam int unsigned DLY_MID_US = 1000;
  localparam int unsigned DLY_LONG_US = 3000;
  localparam int unsigned DLY_SHORT_CYC = DLY_SHORT_US * CLK_MHZ;
  localparam int unsigned DLY_MID_CYC = DLY_MID_US * CLK_MHZ;
  localparam int unsigned DLY_LONG_CYC = DLY_LONG_US * CLK_MHZ;
  localparam int unsigned NUM_BYTES = 4;
  localparam logic [7:0] SHARED_ADDR = 8'h00;
  localparam logic [7:0] MIN_DIRECT_ADDR = 8'h80;
  localparam logic [7:0] IN_RST = 8'h00;
  localparam logic [1:0] SCAN_RST = 2'h0;
  typedef enum logic [1:0] {
    EIDI_EDGE_NONE = 2'b00,
    EIDI_EDGE_RISE = 2'b01,
    EIDI_EDGE_FALL = 2'b10,
    EIDI_EDGE_BOTH = 2'b11
  } eidi_edge_t;
  typedef enum logic [1:0] {
    EIDI_DLY_SHORT = 2'b00,
    EIDI_DLY_MID = 2'b01,
    EIDI_DLY_LONG = 2'b10
  } eidi_dly_t;
endpackage : eidi_pkg

// ===== logic/eidi_byte_filter.sv
`timescale 1ns/100ps
// one input byte: sync, settle delay, edge capture into a pending flag
module eidi_byte_filter #(
  parameter int unsigned SHORT_CYC = eidi_pkg::DLY_SHORT_CYC,
  parameter int unsigned MID_CYC = eidi_pkg::DLY_MID_CYC,
  parameter int unsigned LONG_CYC = eidi_pkg::DLY_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] pin_i,
  input wire logic [1:0] dly_sel_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic freeze_i,
  input wire logic clear_i,
  output logic [7:0] value_o,
  output logic pend_o
);
  // the settle counter is 22 bits wide, so longer delays cannot be served
  if (LONG_CYC < 2 || SHORT_CYC < 1 || MID_CYC < 1 || LONG_CYC > 4194304 || MID_CYC > 4194304 ||
      SHORT_CYC > 4194304) begin : g_bad_delay
    $error("delay counts out of range");
  end
  logic [7:0] s1_q, s2_q, cand_q, val_q;
  logic [21:0] cnt_q;
  logic pend_q;
  wire [21:0] lim = (dly_sel_i == eidi_pkg::EIDI_DLY_SHORT) ? 22'(SHORT_CYC) :
                    (dly_sel_i == eidi_pkg::EIDI_DLY_MID) ? 22'(MID_CYC) : 22'(LONG_CYC);
  wire settled = (cnt_q >= lim - 22'h1);
  // while frozen the settled value is held; edges wait until release
  wire take = settled && !freeze_i && (cand_q != val_q);
  wire [7:0] rise = ~val_q & cand_q;
  wire [7:0] fall = val_q & ~cand_q;
  wire hit = take && (((edge_sel_i == eidi_pkg::EIDI_EDGE_RISE || edge_sel_i == eidi_pkg::EIDI_EDGE_BOTH) &&
              (|rise)) || ((edge_sel_i == eidi_pkg::EIDI_EDGE_FALL || edge_sel_i == eidi_pkg::EIDI_EDGE_BOTH) &&
              (|fall)));
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= eidi_pkg::IN_RST;
      s2_q <= eidi_pkg::IN_RST;
      cand_q <= eidi_pkg::IN_RST;
      val_q <= eidi_pkg::IN_RST;
      cnt_q <= '0;
      pend_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      cand_q <= s2_q;
      if (s2_q != cand_q) cnt_q <= '0;
      else if (!settled) cnt_q <= cnt_q + 22'h1;
      if (take) val_q <= cand_q;
      // set wins over a same-cycle clear
      if (hit) pend_q <= 1'b1;
      else if (clear_i) pend_q <= 1'b0;
    end
  end
  assign value_o = val_q;
  assign pend_o = pend_q;
endmodule : eidi_byte_filter

// ===== tb/eidi_ctrl_model.sv
`timescale 1ns/100ps
module eidi_ctrl_model (
  input wire logic clk_i,
  input wire logic rdy_i,
  input wire logic oe_i,
  input wire logic [7:0] data_i,
  output logic [7:0] addr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
  end
  // strobe held until ack is seen; gives up after four cycles so a refused read cannot hang
  task automatic rd(input logic [7:0] a, output logic ack, output logic [7:0] d);
    ack = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    #1 addr_o = a;
    rd_o = 1'b1;
    for (int i = 0; i < 4 && !ack; i++) begin
      @(posedge clk_i);
      #1 ack = (rdy_i === 1'b1);
      if (oe_i === 1'b1) d = data_i;
    end
    @(posedge clk_i);
    #1 rd_o = 1'b0;
  endtask : rd
  // one ascending pass, each own byte exactly once, also used as the start-up read
  task automatic scan(input logic [7:0] base, output logic [7:0] q [4]);
    logic ack;
    for (int k = 0; k < 4; k++) rd(base + 8'(k), ack, q[k]);
  endtask : scan
endmodule : eidi_ctrl_model

// ===== tb/test_edge_interrupt_digital_input.sv
`timescale 1ns/100ps
module test_edge_interrupt_digital_input;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [31:0] pin = 32'h0;
  logic [7:0] base = 8'h80;
  logic [2:0] bsel = 3'h0;
  logic [7:0] route = 8'h04;
  logic [7:0] edge_sel = 8'he1;
  logic [7:0] dly = 8'h02;
  logic mst = 1'b1;
  logic ackj = 1'b1;
  logic irqm = 1'b0;
  logic [7:0] addr, data, irq, d;
  logic rd, oe, rdy, pend, frz, ack;
  logic [7:0] q [4];
  int num_errors = 0;
  int checks = 0;
  always #2 clk_i = ~clk_i;
  eidi_top #(.SHORT_CYC(4), .MID_CYC(8), .LONG_CYC(16)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .pin_i(pin),
    .bus_addr_i(addr), .bus_rd_i(rd), .bus_data_o(data), .bus_data_oe_o(oe), .bus_rdy_o(rdy),
    .base_address_switch_i(base), .group_bit_select_switch_i(bsel), .irq_line_route_switch_i(route),
    .edge_select_switch_i(edge_sel), .input_delay_switch_i(dly), .master_select_jumper_i(mst),
    .group_ack_jumper_i(ackj), .irq_mode_i(irqm), .irq_line_o(irq), .pending_o(pend), .frozen_o(frz));
  eidi_ctrl_model ctrl (.clk_i(clk_i), .rdy_i(rdy), .oe_i(oe), .data_i(data), .addr_o(addr), .rd_o(rd));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // lands just after an edge so inputs never change on the sampling edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc
  // master, group mode: byte 1 has no edge, byte 0 rises behind the long delay
  task automatic t_group();
    pin[8] = 1'b1;
    wait_cyc(12);
    check(pend, 1'b0);
    pin[0] = 1'b1;
    wait_cyc(10);
    check(pend, 1'b0);
    wait_cyc(15);
    check({pend, irq}, 9'h100);
    ctrl.rd(8'h00, ack, d);
    check({ack, d}, 9'h101);
    ctrl.rd(base + 8'h04, ack, d);
    check(ack, 1'b0);
    ctrl.rd(base, ack, d);
    check({frz, pend, ack, d}, 11'h701);
    ctrl.rd(base + 8'h01, ack, d);
    check(d, 8'h01);
    ctrl.rd(base + 8'h02, ack, d);
    ctrl.rd(base + 8'h03, ack, d);
    wait_cyc(2);
    check({frz, pend}, 2'b00);
    $display("test group done");
  endtask : t_group
  // slave on bit 3, interrupt mode, byte 3 on both edges; a change during freeze is deferred
  task automatic t_irq();
    irqm = 1'b1;
    mst = 1'b0;
    bsel = 3'h3;
    ackj = 1'b0;
    pin[24] = 1'b1;
    wait_cyc(12);
    check(irq, 8'h04);
    ctrl.rd(8'h00, ack, d);
    check({ack, d}, 9'h008);
    ctrl.rd(base, ack, d);
    pin[24] = 1'b0;
    wait_cyc(12);
    for (int k = 1; k < 4; k++) ctrl.rd(base + 8'(k), ack, d);
    wait_cyc(12);
    check({frz, pend}, 2'b01);
    ctrl.scan(base, q);
    wait_cyc(2);
    check({q[3], irq}, 16'h0000);
    $display("test irq done");
  endtask : t_irq
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    wait_cyc(10);
    arst_n_i = 1'b1;
    wait_cyc(2);
    ctrl.scan(base, q);
    t_group();
    t_irq();
    complete_run();
  end
  initial begin
    #8000;
    num_errors++;
    complete_run();
  end
endmodule : test_edge_interrupt_digital_input
